// ===== core/rcl_defines.svh
`ifndef RCL_DEFINES_SVH
`define RCL_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define RCL_IDX_CFG1        10'h000
`define RCL_IDX_RTCFG       10'h017
`define RCL_IDX_STATUS      10'h018
`define RCL_IDX_TBL_BASE    10'h200
`define RCL_IDX_TBL_LAST    10'h2ff

// Configuration bit positions and reset values.
`define RCL_CFG1_RUN_BIT    13
`define RCL_RTCFG_BCST_BIT  0
`define RCL_CFG1_RST        16'h0000
`define RCL_RTCFG_RST       16'h0000

// Command word field positions.
`define RCL_TA_LSB          11
`define RCL_TR_BIT          10
`define RCL_SA_LSB          5
`define RCL_WC_LSB          0

// Field values with a fixed meaning.
`define RCL_BCST_TA         5'h1f
`define RCL_SA_MODE_LO      5'h00
`define RCL_SA_MODE_HI      5'h1f
`define RCL_TBL_WORDS       256
`define RCL_FULL_COUNT      6'h20

`endif

// ===== core/rcl_pkg.sv
`default_nettype none

package rcl_pkg;

  // Kind of answer given to a command addressed to this terminal.
  typedef enum logic [1:0] {
    RCL_RESP_SILENT,
    RCL_RESP_IN_FORM,
    RCL_RESP_MSG_ERR
  } rcl_resp_t;

  // Command sequencing states.
  typedef enum logic [1:0] {
    RCL_ST_IDLE,
    RCL_ST_PEND,
    RCL_ST_LOOK,
    RCL_ST_DECIDE
  } rcl_state_t;

endpackage

`default_nettype wire

// ===== core/rcl_ram_if.sv
`timescale 1ns/1ps
`default_nettype none

// Host port and lookup port of the legality table memory.
interface rcl_ram_if;
  logic        h_we;
  logic [7:0]  h_addr;
  logic [15:0] h_wdata;
  logic [15:0] h_rdata;
  logic [7:0]  l_addr;
  logic [15:0] l_rdata;
  logic        ready;

  modport ctrl (output h_we, output h_addr, output h_wdata, output l_addr,
                input h_rdata, input l_rdata, input ready);
  modport mem  (input h_we, input h_addr, input h_wdata, input l_addr,
                output h_rdata, output l_rdata, output ready);
endinterface

`default_nettype wire

// ===== core/rcl_table_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcl_defines.svh"

module rcl_table_ram #(
  parameter int DEPTH = `RCL_TBL_WORDS
) (
  input wire logic clock,
  input wire logic nrst,
  rcl_ram_if.mem   bus
);

  logic [15:0] mem_q [DEPTH];
  logic [7:0]  clr_q;
  logic        clearing_q;
  logic        ready_q;
  logic [15:0] h_rdata_q;
  logic [15:0] l_rdata_q;

  // Self test sweep: every word is cleared once after reset before ready rises.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clr_q      <= 8'h00;
      clearing_q <= 1'b1;
      ready_q    <= 1'b0;
    end else if (clearing_q) begin
      clr_q <= clr_q + 8'h01;
      if (clr_q == 8'(DEPTH - 1)) begin
        clearing_q <= 1'b0;
        ready_q    <= 1'b1;
      end
    end
  end

  // The array has no reset of its own; the sweep zeroes it instead.
  always_ff @(posedge clock) begin
    if (clearing_q) begin
      mem_q[clr_q] <= 16'h0000;
    end else if (bus.h_we) begin
      mem_q[bus.h_addr] <= bus.h_wdata;
    end
  end

  // Both ports read synchronously, one cycle after the address.
  always_ff @(posedge clock) begin
    h_rdata_q <= mem_q[bus.h_addr];
    l_rdata_q <= mem_q[bus.l_addr];
  end

  // Read data and ready leave through the interface straight from registers.
  assign bus.h_rdata = h_rdata_q;
  assign bus.l_rdata = l_rdata_q;
  assign bus.ready   = ready_q;

  a_clear_done: assert property (@(posedge clock) disable iff (!nrst)
    $rose(ready_q) |-> $past(clr_q) == 8'(DEPTH - 1))
    else $error("ready rose before the clear sweep finished");

endmodule // rcl_table_ram

`default_nettype wire

// ===== core/rcl_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcl_defines.svh"

module rcl_cmd_decode (
  input  wire logic [15:0] word,
  input  wire logic [4:0]  rt_addr,
  input  wire logic        broadcast_reject_cfg,
  output logic      [4:0]  terminal_address_field,
  output logic             tr,
  output logic      [4:0]  sub_address_field,
  output logic      [4:0]  word_count_field,
  output logic             is_mode,
  output logic             own,
  output logic             bcst
);

  // Split the command word into its fields.
  assign terminal_address_field = word[`RCL_TA_LSB +: 5];
  assign tr                     = word[`RCL_TR_BIT];
  assign sub_address_field      = word[`RCL_SA_LSB +: 5];
  assign word_count_field       = word[`RCL_WC_LSB +: 5];

  // Subaddress zero and all-ones both mean a mode command.
  assign is_mode = (sub_address_field == `RCL_SA_MODE_LO) ||
                   (sub_address_field == `RCL_SA_MODE_HI);

  // Address 31 is never an own address; with rejection set it is nobody's.
  assign own  = (terminal_address_field == rt_addr) &&
                (terminal_address_field != `RCL_BCST_TA);
  assign bcst = (terminal_address_field == `RCL_BCST_TA) && !broadcast_reject_cfg;

endmodule // rcl_cmd_decode

`default_nettype wire

// ===== core/rcl_legality_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcl_defines.svh"

module rcl_legality_top
  import rcl_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [4:0]        rt_addr,
  input  wire logic              cmd_valid,
  input  wire logic [15:0]       cmd_word,
  input  wire logic              cmd_follows,
  input  wire logic              word_end,
  output logic                   ready,
  output logic                   resp_valid,
  output rcl_resp_t              resp_kind,
  output logic      [5:0]        resp_words,
  output logic                   resp_transmit,
  output logic                   resp_rt_to_rt_flag,
  output logic                   resp_broadcast,
  output logic                   status_update
);

  rcl_ram_if ram ();

  rcl_state_t  state_q;
  logic [15:0] cfg1_q;
  logic [15:0] rtcfg_q;
  logic [10:0] last_status_q;
  logic [15:0] pend_word_q;
  logic [15:0] sel_word_q;
  logic        sel_bcst_q;
  logic        sel_rt_to_rt_flag_q;
  logic        sel_silent_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        ready_q;
  logic        resp_valid_q;
  rcl_resp_t   resp_kind_q;
  logic [5:0]  resp_words_q;
  logic        resp_transmit_q;
  logic        resp_rt_to_rt_flag_q;
  logic        resp_bcst_q;
  logic        status_update_q;

  logic        terminal_run_start;
  logic        broadcast_reject_cfg;
  logic        accept;
  logic        take;
  logic        to_pend;
  logic [15:0] t_word;
  logic        t_bcst;
  logic        t_rt_to_rt_flag;
  logic        t_silent;
  logic        fetched_bit;
  logic        sel_mode;
  logic [5:0]  sel_count;

  logic [4:0]  nw_ta, nw_sa, nw_wc, pd_ta, pd_sa, pd_wc, sl_ta, sl_sa, sl_wc;
  logic        nw_tr, nw_mode, nw_own, nw_bcst;
  logic        pd_tr, pd_mode, pd_own, pd_bcst;
  logic        sl_tr, sl_own, sl_bcst;

  logic [9:0]  idx;
  logic        in_tbl;
  logic        mapped;
  logic        apb_access;
  logic        apb_commit;

  // Control bits taken from the two configuration words.
  assign terminal_run_start   = cfg1_q[`RCL_CFG1_RUN_BIT];
  assign broadcast_reject_cfg = rtcfg_q[`RCL_RTCFG_BCST_BIT];

  // The 256-word table with its self-clearing sweep.
  rcl_table_ram #(.DEPTH(`RCL_TBL_WORDS)) u_ram (
    .clock (clock),
    .nrst  (nrst),
    .bus   (ram.mem)
  );

  // Decoder for the word arriving now.
  rcl_cmd_decode u_dec_new (
    .word                   (cmd_word),
    .rt_addr                (rt_addr),
    .broadcast_reject_cfg   (broadcast_reject_cfg),
    .terminal_address_field (nw_ta),
    .tr                     (nw_tr),
    .sub_address_field      (nw_sa),
    .word_count_field       (nw_wc),
    .is_mode                (nw_mode),
    .own                    (nw_own),
    .bcst                   (nw_bcst)
  );

  // Decoder for a receive word held while we wait to see if a pair follows.
  rcl_cmd_decode u_dec_pend (
    .word                   (pend_word_q),
    .rt_addr                (rt_addr),
    .broadcast_reject_cfg   (broadcast_reject_cfg),
    .terminal_address_field (pd_ta),
    .tr                     (pd_tr),
    .sub_address_field      (pd_sa),
    .word_count_field       (pd_wc),
    .is_mode                (pd_mode),
    .own                    (pd_own),
    .bcst                   (pd_bcst)
  );

  // Decoder for the word chosen for lookup.
  rcl_cmd_decode u_dec_sel (
    .word                   (sel_word_q),
    .rt_addr                (rt_addr),
    .broadcast_reject_cfg   (broadcast_reject_cfg),
    .terminal_address_field (sl_ta),
    .tr                     (sl_tr),
    .sub_address_field      (sl_sa),
    .word_count_field       (sl_wc),
    .is_mode                (sel_mode),
    .own                    (sl_own),
    .bcst                   (sl_bcst)
  );

  // Commands count only once software has started the terminal.
  assign accept = cmd_valid && terminal_run_start && ram.ready;

  // Classify the arriving or pending command. A receive word is held,
  // because only the next word tells whether it opens a pair.
  always_comb begin
    take     = 1'b0;
    to_pend  = 1'b0;
    t_word   = cmd_word;
    t_bcst   = nw_bcst;
    t_rt_to_rt_flag   = 1'b0;
    t_silent = 1'b0;
    if (state_q == RCL_ST_PEND && !accept && word_end) begin
      t_word = pend_word_q;
      t_bcst = pd_bcst;
      take   = pd_own || pd_bcst;
    end else if (accept && (state_q == RCL_ST_IDLE || state_q == RCL_ST_PEND)) begin
      if (state_q == RCL_ST_PEND && cmd_follows && nw_tr) begin
        if (pd_mode || nw_mode || nw_ta == `RCL_BCST_TA) begin
          take     = pd_own || pd_bcst || nw_own;
          t_word   = pend_word_q;
          t_bcst   = pd_bcst;
          t_silent = 1'b1;
        end else if (pd_own || pd_bcst) begin
          take   = 1'b1;
          t_word = pend_word_q;
          t_bcst = pd_bcst;
          t_rt_to_rt_flag = 1'b1;
        end else if (nw_own) begin
          take   = 1'b1;
          t_bcst = 1'b0;
        end
      end else if (!nw_tr) begin
        to_pend = 1'b1;
      end else begin
        take     = nw_own || nw_bcst;
        t_silent = nw_bcst && !nw_mode;
      end
    end
  end

  // Sequencer: hold, look up, decide. A word arriving during the two
  // lookup cycles is dropped; bus command spacing is far longer than that.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q      <= RCL_ST_IDLE;
      pend_word_q  <= 16'h0000;
      sel_word_q   <= 16'h0000;
      sel_bcst_q   <= 1'b0;
      sel_rt_to_rt_flag_q   <= 1'b0;
      sel_silent_q <= 1'b0;
    end else begin
      case (state_q)
        RCL_ST_IDLE, RCL_ST_PEND: begin
          if (take) begin
            sel_word_q   <= t_word;
            sel_bcst_q   <= t_bcst;
            sel_rt_to_rt_flag_q   <= t_rt_to_rt_flag;
            sel_silent_q <= t_silent;
            state_q      <= RCL_ST_LOOK;
          end else if (to_pend) begin
            pend_word_q <= cmd_word;
            state_q     <= RCL_ST_PEND;
          end else if (state_q == RCL_ST_PEND && (accept || word_end)) begin
            state_q <= RCL_ST_IDLE;
          end
        end
        RCL_ST_LOOK:   state_q <= RCL_ST_DECIDE;
        RCL_ST_DECIDE: state_q <= RCL_ST_IDLE;
        default:       state_q <= RCL_ST_IDLE;
      endcase
    end
  end

  // Table word: not-broadcast, direction, subaddress, count MSB.
  assign ram.l_addr = {~sel_bcst_q, sl_tr, sl_sa, sl_wc[4]};
  // The four low count bits pick the bit in either word.
  assign fetched_bit = ram.l_rdata[sl_wc[3:0]];
  // Mode codes 16-31 carry one data word; a zero count means 32.
  assign sel_count = sel_mode ? {5'h00, sl_wc[4]} :
                     (sl_wc == 5'h00) ? `RCL_FULL_COUNT : {1'b0, sl_wc};

  // Answer and stored status, produced one cycle after the table word arrives.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      resp_valid_q    <= 1'b0;
      resp_kind_q     <= RCL_RESP_SILENT;
      resp_words_q    <= 6'h00;
      resp_transmit_q <= 1'b0;
      resp_rt_to_rt_flag_q     <= 1'b0;
      resp_bcst_q     <= 1'b0;
      status_update_q <= 1'b0;
    end else begin
      resp_valid_q    <= (state_q == RCL_ST_DECIDE);
      status_update_q <= (state_q == RCL_ST_DECIDE) && !sel_silent_q;
      if (state_q == RCL_ST_DECIDE) begin
        resp_transmit_q <= sl_tr;
        resp_rt_to_rt_flag_q     <= sel_rt_to_rt_flag_q;
        resp_bcst_q     <= sel_bcst_q;
        if (sel_silent_q) begin
          resp_kind_q  <= RCL_RESP_SILENT;
          resp_words_q <= 6'h00;
        end else if (fetched_bit) begin
          resp_kind_q  <= RCL_RESP_MSG_ERR;
          resp_words_q <= 6'h00;
        end else begin
          resp_kind_q  <= RCL_RESP_IN_FORM;
          resp_words_q <= sel_count;
        end
      end
    end
  end

  // Status seen by later status requests changes only on a real answer.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_status_q <= 11'h000;
    end else if (status_update_q) begin
      last_status_q <= {resp_words_q, resp_bcst_q, resp_rt_to_rt_flag_q, resp_transmit_q,
                        resp_kind_q};
    end
  end

  // APB decode; registers sit at four times their index.
  assign idx        = paddr[11:2];
  assign in_tbl     = (idx >= `RCL_IDX_TBL_BASE) && (idx <= `RCL_IDX_TBL_LAST);
  assign mapped     = (paddr[1:0] == 2'b00) &&
                      (in_tbl || idx == `RCL_IDX_CFG1 || idx == `RCL_IDX_RTCFG ||
                       idx == `RCL_IDX_STATUS);
  assign apb_access = psel && penable && !pready_q;
  assign apb_commit = psel && penable && pready_q && pwrite && mapped;

  // The table read is issued from the setup cycle's address.
  assign ram.h_addr  = idx[7:0];
  assign ram.h_wdata = pwdata[15:0];
  assign ram.h_we    = apb_commit && in_tbl;

  // One wait state per transfer; table access also waits for the sweep.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= 1'b0;
      if (apb_access && (ram.ready || !in_tbl)) begin
        pready_q  <= 1'b1;
        pslverr_q <= !mapped;
        if (!mapped || pwrite) begin
          prdata_q <= 32'h0000_0000;
        end else if (in_tbl) begin
          prdata_q <= {16'h0000, ram.h_rdata};
        end else if (idx == `RCL_IDX_CFG1) begin
          prdata_q <= {16'h0000, cfg1_q};
        end else if (idx == `RCL_IDX_RTCFG) begin
          prdata_q <= {16'h0000, rtcfg_q};
        end else begin
          prdata_q <= {21'h000000, last_status_q};
        end
      end
    end
  end

  // Configuration writes land on the completing edge only.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg1_q  <= `RCL_CFG1_RST;
      rtcfg_q <= `RCL_RTCFG_RST;
    end else if (apb_commit) begin
      if (idx == `RCL_IDX_CFG1) begin
        cfg1_q <= pwdata[15:0];
      end
      if (idx == `RCL_IDX_RTCFG) begin
        rtcfg_q <= pwdata[15:0];
      end
    end
  end

  // Ready is re-timed so the port comes from a flip-flop.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ram.ready;
    end
  end

  // Every port is driven straight from its register.
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign ready              = ready_q;
  assign resp_valid         = resp_valid_q;
  assign resp_kind          = resp_kind_q;
  assign resp_words         = resp_words_q;
  assign resp_transmit      = resp_transmit_q;
  assign resp_rt_to_rt_flag = resp_rt_to_rt_flag_q;
  assign resp_broadcast     = resp_bcst_q;
  assign status_update      = status_update_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_pair_mode_silent: assert property (
    (state_q == RCL_ST_PEND && accept && cmd_follows && nw_tr && (pd_mode || nw_mode) && take)
    |-> ##3 resp_valid_q && resp_kind_q == RCL_RESP_SILENT)
    else $error("mode pair was not answered silently");
  a_silent_no_status: assert property (
    resp_valid_q && resp_kind_q == RCL_RESP_SILENT |-> !status_update_q)
    else $error("silent answer updated status");
  a_pair_bcst_second: assert property (
    (state_q == RCL_ST_PEND && accept && cmd_follows && nw_tr && nw_ta == `RCL_BCST_TA)
    |-> ##3 !resp_valid_q || resp_kind_q == RCL_RESP_SILENT)
    else $error("pair with broadcast second word answered");
  a_bcst_tx_silent: assert property (
    (state_q == RCL_ST_IDLE && accept && nw_tr && nw_bcst && !nw_mode)
    |-> ##3 resp_valid_q && resp_kind_q == RCL_RESP_SILENT && !status_update_q)
    else $error("broadcast transmit was answered");
  a_illegal_no_data: assert property (
    state_q == RCL_ST_DECIDE && !sel_silent_q && fetched_bit
    |=> resp_kind_q == RCL_RESP_MSG_ERR && resp_words_q == 6'h00 && status_update_q)
    else $error("illegal command not answered with message error");
  a_legal_count: assert property (
    state_q == RCL_ST_DECIDE && !sel_silent_q && !fetched_bit && !sel_mode
    |=> resp_kind_q == RCL_RESP_IN_FORM &&
        resp_words_q == (($past(sl_wc) == 5'h00) ? 6'h20 : {1'b0, $past(sl_wc)}))
    else $error("legal command word count wrong");
  a_run_gate: assert property (
    !terminal_run_start && state_q == RCL_ST_IDLE |=> state_q != RCL_ST_LOOK)
    else $error("command processed before run start");
  a_pair_flag_rx: assert property (
    resp_valid_q && resp_rt_to_rt_flag |-> !resp_transmit_q)
    else $error("pair flag on a transmit answer");
  a_lookup_addr: assert property (
    state_q == RCL_ST_LOOK |=> $past(ram.l_addr[7]) == !sel_bcst_q &&
                               $past(ram.l_addr[0]) == sl_wc[4])
    else $error("table word address malformed");

  c_pair_receive:  cover property (resp_valid_q && resp_rt_to_rt_flag);
  c_msg_error:     cover property (resp_valid_q && resp_kind_q == RCL_RESP_MSG_ERR);
  c_silent:        cover property (resp_valid_q && resp_kind_q == RCL_RESP_SILENT);
  c_in_form_tx:    cover property (resp_valid_q && resp_kind_q == RCL_RESP_IN_FORM &&
                                   resp_transmit_q);

endmodule // rcl_legality_top

`default_nettype wire

// ===== dv/rcl_bc_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus controller side: issues command words and marks word gaps.
module rcl_bc_model (
  input  wire logic        clock,
  output logic             cmd_valid,
  output logic      [15:0] cmd_word,
  output logic             cmd_follows,
  output logic             word_end
);
  initial {cmd_valid, cmd_follows, word_end, cmd_word} = '0;

  // Idle word lines show the inverse of the last word, so stale data never looks valid.
  task send(input logic [15:0] w, input logic f);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    cmd_follows <= f;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_follows <= 1'b0;
    cmd_word <= ~w;
  endtask

  // A gap after a lone receive word ends the wait for a second word.
  task gap();
    word_end <= 1'b1;
    @(posedge clock);
    word_end <= 1'b0;
  endtask

  // Receive word first, then the transmit word marked as contiguous with it.
  task pair(input logic [15:0] w1, input logic [15:0] w2);
    send(w1, 1'b0);
    repeat (2) @(posedge clock);
    send(w2, 1'b1);
  endtask
endmodule // rcl_bc_model

`default_nettype wire

// ===== dv/tb_rt_command_legality_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcl_defines.svh"

module tb_rt_command_legality_check;
  import rcl_pkg::*;
  localparam logic [23:0] SIL = 24'hc01000;
  logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic [4:0]  rt_addr = 5'h01;
  logic [4:0]  ra, ob, sa, wc;
  logic        pready, pslverr, er, ready, resp_valid, resp_transmit;
  logic        resp_rt_to_rt_flag, resp_broadcast, status_update;
  logic        cmd_valid, cmd_follows, word_end;
  logic [15:0] cmd_word;
  logic [5:0]  resp_words;
  rcl_resp_t   resp_kind;
  logic [11:0] got;
  logic [23:0] x;
  logic [23:0] exp_q[$];
  int          fails = 0, n_compared = 0, i;

  rcl_legality_top #(.ADDR_W(12)) DUT (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rt_addr, .cmd_valid, .cmd_word, .cmd_follows,
    .word_end, .ready, .resp_valid, .resp_kind, .resp_words, .resp_transmit,
    .resp_rt_to_rt_flag, .resp_broadcast, .status_update);
  rcl_bc_model bc (.clock, .cmd_valid, .cmd_word, .cmd_follows, .word_end);

  always #12.5 clock = ~clock;
  assign got = {resp_kind, resp_words, resp_transmit, resp_rt_to_rt_flag, resp_broadcast,
                status_update};

  task check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task wrap_up();
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Waits for the clear sweep; a timeout ends the run as a failure.
  task wait_ready();
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(posedge clock);
    check({31'h0, ready}, 32'h1);
    if (ready !== 1'b1) wrap_up();
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 400 && pready !== 1'b1; i++) @(posedge clock);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task tw(input logic b, input logic t, input logic [4:0] s, input logic m,
          input logic [15:0] v);
    apb(1'b1, {`RCL_IDX_TBL_BASE + {!b, t, s, m}, 2'b00}, {16'h0, v});
  endtask

  function automatic logic [23:0] ex(rcl_resp_t k, logic [5:0] n, logic t, logic f, logic b);
    return {12'hfff, k, n, t, f, b, k != RCL_RESP_SILENT};
  endfunction

  // A lone receive word waits for the gap before it is decided.
  task run(input logic [15:0] w, input logic [23:0] e, input logic use_e);
    if (use_e) exp_q.push_back(e);
    bc.send(w, 1'b0);
    if (!w[10]) begin
      repeat (2) @(posedge clock);
      bc.gap();
    end
    repeat (6) @(posedge clock);
  endtask

  task pr(input logic [15:0] w1, input logic [15:0] w2, input logic [23:0] e);
    exp_q.push_back(e);
    bc.pair(w1, w2);
    repeat (6) @(posedge clock);
  endtask

  // Every decision is matched against the oldest note; masked bits are left open.
  always @(posedge clock) begin
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else begin
        x = exp_q.pop_front();
        check({20'h0, got & x[23:12]}, {20'h0, x[11:0] & x[23:12]});
      end
    end
  end

  initial begin
    void'($urandom(4321));
    ra = 5'd1 + 5'($urandom % 30);
    ob = (ra == 5'd1) ? 5'd2 : 5'd1;
    rt_addr <= ra;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    wait_ready();
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, {`RCL_IDX_TBL_BASE + 10'($urandom % 256), 2'b00}, 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 12'hc00, 32'h0);
    check({31'h0, er}, 32'h1);
    run({ra, 1'b1, 5'd1, 5'd5}, SIL, 1'b0);
    apb(1'b1, 12'h000, 32'h1 << `RCL_CFG1_RUN_BIT);
    run({ra, 1'b1, 5'd1, 5'd5}, ex(RCL_RESP_IN_FORM, 6'd5, 1, 0, 0), 1'b1);
    for (int k = 0; k < 4; k++) begin
      sa = 5'd1 + 5'($urandom % 30);
      wc = 5'($urandom);
      run({ra, 1'b0, sa, wc}, ex(RCL_RESP_IN_FORM, {wc == 0, wc}, 0, 0, 0), 1'b1);
    end
    tw(0, 1, 5'd1, 0, 16'h0021);
    tw(0, 1, 5'd1, 1, 16'h0004);
    run({ra, 1'b1, 5'd1, 5'd5}, ex(RCL_RESP_MSG_ERR, 0, 1, 0, 0), 1'b1);
    run({ra, 1'b1, 5'd1, 5'd0}, ex(RCL_RESP_MSG_ERR, 0, 1, 0, 0), 1'b1);
    run({ra, 1'b1, 5'd1, 5'd6}, ex(RCL_RESP_IN_FORM, 6'd6, 1, 0, 0), 1'b1);
    run({ra, 1'b1, 5'd1, 5'd18}, ex(RCL_RESP_MSG_ERR, 0, 1, 0, 0), 1'b1);
    run({ra, 1'b0, 5'd1, 5'd5}, ex(RCL_RESP_IN_FORM, 6'd5, 0, 0, 0), 1'b1);
    tw(1, 0, 5'd1, 0, 16'h0020);
    run({5'h1f, 1'b0, 5'd1, 5'd5}, ex(RCL_RESP_MSG_ERR, 0, 0, 0, 1), 1'b1);
    run({ra, 1'b0, 5'd1, 5'd5}, ex(RCL_RESP_IN_FORM, 6'd5, 0, 0, 0), 1'b1);
    tw(0, 1, 5'd31, 1, 16'h0002);
    tw(0, 1, 5'd0, 1, 16'h0002);
    run({ra, 1'b1, 5'd31, 5'd17}, ex(RCL_RESP_MSG_ERR, 0, 1, 0, 0), 1'b1);
    run({ra, 1'b1, 5'd0, 5'd17}, ex(RCL_RESP_MSG_ERR, 0, 1, 0, 0), 1'b1);
    run({ra, 1'b1, 5'd0, 5'd18}, ex(RCL_RESP_IN_FORM, 6'd1, 1, 0, 0), 1'b1);
    run({ra, 1'b1, 5'd31, 5'd2}, ex(RCL_RESP_IN_FORM, 6'd0, 1, 0, 0), 1'b1);
    run({5'h1f, 1'b1, 5'd3, 5'd2}, SIL, 1'b1);
    run({5'h1f, 1'b1, 5'd31, 5'd2}, ex(RCL_RESP_IN_FORM, 6'd0, 1, 0, 1), 1'b1);
    pr({ra, 1'b0, 5'd2, 5'd3}, {ob, 1'b1, 5'd4, 5'd3}, ex(RCL_RESP_IN_FORM, 3, 0, 1, 0));
    pr({ob, 1'b0, 5'd2, 5'd3}, {ra, 1'b1, 5'd4, 5'd3}, ex(RCL_RESP_IN_FORM, 3, 1, 0, 0));
    pr({ra, 1'b0, 5'd2, 5'd3}, {ob, 1'b1, 5'd0, 5'd3}, SIL);
    pr({ob, 1'b0, 5'd31, 5'd17}, {ra, 1'b1, 5'd4, 5'd3}, SIL);
    pr({ra, 1'b0, 5'd2, 5'd3}, {5'h1f, 1'b1, 5'd4, 5'd3}, SIL);
    apb(1'b0, {`RCL_IDX_STATUS, 2'b00}, 32'h0);
    check(rd, 32'h65);
    apb(1'b1, {`RCL_IDX_RTCFG, 2'b00}, 32'h1 << `RCL_RTCFG_BCST_BIT);
    run({5'h1f, 1'b0, 5'd1, 5'd6}, SIL, 1'b0);
    // A reset in mid-run must clear the table and the run bit again.
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    wait_ready();
    apb(1'b0, {`RCL_IDX_TBL_BASE + 10'h0c2, 2'b00}, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, {`RCL_IDX_CFG1, 2'b00}, 32'h0);
    check(rd, 32'h0);
    run({ra, 1'b1, 5'd1, 5'd5}, SIL, 1'b0);
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clock);
    if (exp_q.size() > 0) fails++;
    wrap_up();
  end
endmodule // tb_rt_command_legality_check

`default_nettype wire
